// ### eicpin_pkg.sv
// Constants, types and register map of the pin interrupt flag block
// How it works
// - Line trigger sets its external flag
// - Line request needs flag (low pin in low level mode), enable, global enable
// - Vector acknowledge clears matching flag
// - Writing one clears flag, zero keeps
// - Low level sensing holds flag at zero
// - Sleep clamps disabled lines 3..0 low
// - Group 2 unmasked change requests group2 vector
// - Group 1 unmasked change requests group1 vector
// - Group 0 unmasked change requests group0 vector
// - Any enabled pin change sets group flag
// - Group request needs flag, enable, global enable
// - Mask bit enables change detection per pin
// - Mask bits map in order onto pins
// - Line enables gate requests, pins as outputs
// - Sense select: low, change, fall, rise
package eicpin_pkg;
   typedef logic [7:0] eicpin_byte_t;
   typedef logic [3:0] eicpin_vidx_t;
   // -----------------------------------------
   // Register offsets
   // -----------------------------------------
   localparam eicpin_byte_t ADDR_EXT_FLAG = 8'h3c;
   localparam eicpin_byte_t ADDR_EXT_EN = 8'h3d;
   localparam eicpin_byte_t ADDR_SENSE_LO = 8'h69;
   localparam eicpin_byte_t ADDR_SENSE_HI = 8'h6a;
   localparam eicpin_byte_t ADDR_MASK0 = 8'h6b;
   localparam eicpin_byte_t ADDR_MASK1 = 8'h6c;
   localparam eicpin_byte_t ADDR_MASK2 = 8'h6d;
   localparam eicpin_byte_t ADDR_GRP_EN = 8'h70;
   localparam eicpin_byte_t ADDR_GRP_FLAG = 8'h71;
   // -----------------------------------------
   // Sizes, reset values, encodings
   // -----------------------------------------
   localparam int EXT_NUM = 8;
   localparam int GRP_NUM = 3;
   localparam int GRP_PINS = 8;
   localparam int CHG_NUM = 24;
   localparam int SLEEP_LINES = 4;
   localparam eicpin_byte_t REG_RESET = 8'h00;
   localparam logic [2:0] GRP_RESET = 3'h0;
   localparam logic [1:0] SENSE_LOW = 2'h0;
   localparam logic [1:0] SENSE_ANY = 2'h1;
   localparam logic [1:0] SENSE_FALL = 2'h2;
   localparam logic [1:0] SENSE_RISE = 2'h3;
   localparam eicpin_vidx_t VEC_GRP_BASE = 4'h8;
endpackage : eicpin_pkg

// ### eicpin_det_if.sv
// Detection results passed from the sense stage to the flag logic
`timescale 1ns/1ps
interface eicpin_det_if;
   logic [7:0] trig;
   logic [7:0] level_mode;
   logic [7:0] pin_low;
   modport src (output trig, output level_mode, output pin_low);
   modport dst (input trig, input level_mode, input pin_low);
endinterface : eicpin_det_if

// ### eicpin_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module eicpin_sync #(
   parameter int W = 32
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   logic [W-1:0] meta;
   logic [W-1:0] next_meta;
   logic [W-1:0] next_q;

   always_comb begin
      next_meta = i_d;
      next_q = meta;
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         meta <= '0;
         o_q <= '0;
      end else begin
         meta <= next_meta;
         o_q <= next_q;
      end
   end

   AST_SYNC_DELAY: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      ##2 o_q == $past(i_d, 2)) else $error("Synchroniser delay is not two cycles");
endmodule : eicpin_sync

// ### eicpin_sense.sv
// Sense select decoding and edge detection for the external lines
`timescale 1ns/1ps
module eicpin_sense (
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   input wire logic [7:0] i_pins,
   input wire logic [15:0] i_sense,
   input wire logic [7:0] i_enables,
   input wire logic i_sleep,
   eicpin_det_if.src det
);
   import eicpin_pkg::*;
   logic [7:0] eff;
   logic [7:0] trig;
   logic [7:0] prev;
   logic [7:0] next_prev;

   for (genvar i = 0; i < EXT_NUM; i++) begin : g_line
      logic [1:0] sel;
      logic hit;
      assign sel = i_sense[2*i +: 2];
      if (i < SLEEP_LINES) begin : g_clamp
         assign eff[i] = i_pins[i] & ~(i_sleep & ~i_enables[i]);
      end else begin : g_open
         assign eff[i] = i_pins[i];
      end
      always_comb begin
         case (sel)
            SENSE_ANY: hit = eff[i] ^ prev[i];
            SENSE_FALL: hit = prev[i] & ~eff[i];
            SENSE_RISE: hit = eff[i] & ~prev[i];
            default: hit = 1'b0;
         endcase
      end
      assign trig[i] = hit;
      assign det.level_mode[i] = (sel == SENSE_LOW);
   end

   assign det.pin_low = ~eff;
   assign det.trig = trig;

   always_comb begin
      next_prev = eff;
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         prev <= REG_RESET;
      end else begin
         prev <= next_prev;
      end
   end
endmodule : eicpin_sense

// ### eicpin_top.sv
// External line and pin change interrupt flags with register port
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
module eicpin_top (
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   input wire eicpin_pkg::eicpin_byte_t i_addr,
   input wire eicpin_pkg::eicpin_byte_t i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output eicpin_pkg::eicpin_byte_t o_rdata,
   input wire logic [7:0] i_ext_pins,
   input wire logic [23:0] i_change_pins,
   input wire logic i_global_irq_en,
   input wire logic i_sleep,
   input wire logic i_vec_ack,
   input wire eicpin_pkg::eicpin_vidx_t i_vec_idx,
   output logic [7:0] o_ext_req,
   output logic [2:0] o_grp_req,
   output logic o_irq
);
   import eicpin_pkg::*;

   // -----------------------------------------
   // Declarations
   // -----------------------------------------
   eicpin_det_if det ();

   logic [31:0] pins_sync;
   logic [7:0] ext_sync;
   logic [23:0] chg_sync;
   logic [23:0] chg_prev;
   logic [23:0] next_chg_prev;
   logic [23:0] chg;
   logic [23:0] mask_all;
   logic [2:0] grp_set;
   logic [15:0] sense_all;

   eicpin_byte_t ext_line_enable_reg;
   eicpin_byte_t ext_line_flags;
   eicpin_byte_t sense_lo;
   eicpin_byte_t sense_hi;
   eicpin_byte_t group0_mask_reg;
   eicpin_byte_t group1_mask_reg;
   eicpin_byte_t group2_mask_reg;
   logic [2:0] group_enable_reg;
   logic [2:0] group_flags;

   eicpin_byte_t next_ext_en;
   eicpin_byte_t next_ext_flags;
   eicpin_byte_t next_sense_lo;
   eicpin_byte_t next_sense_hi;
   eicpin_byte_t next_mask0;
   eicpin_byte_t next_mask1;
   eicpin_byte_t next_mask2;
   logic [2:0] next_grp_en;
   logic [2:0] next_grp_flags;
   eicpin_byte_t next_rdata;

   eicpin_byte_t wclr_ext;
   logic [2:0] wclr_grp;
   logic [7:0] ack_ext;
   logic [2:0] ack_grp;

   // -----------------------------------------
   // Pin synchronisation and line sensing
   // -----------------------------------------
   eicpin_sync #(
      .W(EXT_NUM + CHG_NUM)
   ) u_sync (
      .i_sys_clk(i_sys_clk),
      .i_rst_b(i_rst_b),
      .i_d({i_change_pins, i_ext_pins}),
      .o_q(pins_sync)
   );

   assign ext_sync = pins_sync[7:0];
   assign chg_sync = pins_sync[31:8];
   assign sense_all = {sense_hi, sense_lo};

   eicpin_sense u_sense (
      .i_sys_clk(i_sys_clk),
      .i_rst_b(i_rst_b),
      .i_pins(ext_sync),
      .i_sense(sense_all),
      .i_enables(ext_line_enable_reg),
      .i_sleep(i_sleep),
      .det(det.src)
   );

   // -----------------------------------------
   // Pin change detection per group
   // -----------------------------------------
   assign mask_all = {group2_mask_reg, group1_mask_reg, group0_mask_reg};
   assign chg = chg_sync ^ chg_prev;

   for (genvar g = 0; g < GRP_NUM; g++) begin : g_grp
      assign grp_set[g] = |(chg[g*GRP_PINS +: GRP_PINS] & mask_all[g*GRP_PINS +: GRP_PINS]);
      assign ack_grp[g] = i_vec_ack && (i_vec_idx == VEC_GRP_BASE + 4'(g));

      AST_GRP_MASK: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
         ((chg[g*GRP_PINS +: GRP_PINS] & mask_all[g*GRP_PINS +: GRP_PINS]) == 8'h00)
         && !group_flags[g] |=> !group_flags[g])
         else $error("Masked pin change set its group flag");
   end

   for (genvar e = 0; e < EXT_NUM; e++) begin : g_ext
      assign ack_ext[e] = i_vec_ack && (i_vec_idx == 4'(e));

      AST_EXT_RISE: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
         (sense_all[2*e +: 2] == SENSE_RISE) && !i_sleep && !$past(i_sleep)
         && $rose(ext_sync[e]) |=> ext_line_flags[e])
         else $error("Rising edge did not set its line flag");

      AST_EXT_FALL: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
         (sense_all[2*e +: 2] == SENSE_FALL) && !i_sleep && !$past(i_sleep)
         && $fell(ext_sync[e]) |=> ext_line_flags[e])
         else $error("Falling edge did not set its line flag");

      AST_EXT_ANY: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
         (sense_all[2*e +: 2] == SENSE_ANY) && !i_sleep && !$past(i_sleep)
         && $changed(ext_sync[e]) |=> ext_line_flags[e])
         else $error("Pin change did not set its line flag");
   end

   always_comb begin
      next_chg_prev = chg_sync;
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         chg_prev <= '0;
      end else begin
         chg_prev <= next_chg_prev;
      end
   end

   // -----------------------------------------
   // Register writes and flag updates
   // -----------------------------------------
   always_comb begin
      next_ext_en = ext_line_enable_reg;
      next_sense_lo = sense_lo;
      next_sense_hi = sense_hi;
      next_mask0 = group0_mask_reg;
      next_mask1 = group1_mask_reg;
      next_mask2 = group2_mask_reg;
      next_grp_en = group_enable_reg;
      wclr_ext = REG_RESET;
      wclr_grp = GRP_RESET;
      if (i_wr) begin
         case (i_addr)
            ADDR_EXT_EN: next_ext_en = i_wdata;
            ADDR_SENSE_LO: next_sense_lo = i_wdata;
            ADDR_SENSE_HI: next_sense_hi = i_wdata;
            ADDR_MASK0: next_mask0 = i_wdata;
            ADDR_MASK1: next_mask1 = i_wdata;
            ADDR_MASK2: next_mask2 = i_wdata;
            ADDR_GRP_EN: next_grp_en = i_wdata[2:0];
            ADDR_EXT_FLAG: wclr_ext = i_wdata;
            ADDR_GRP_FLAG: wclr_grp = i_wdata[2:0];
            default: ;
         endcase
      end
      // Setting wins over clearing in the same cycle
      next_ext_flags = (ext_line_flags & ~wclr_ext & ~ack_ext) | det.trig;
      next_ext_flags = next_ext_flags & ~det.level_mode;
      next_grp_flags = (group_flags & ~wclr_grp & ~ack_grp) | grp_set;
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ext_line_enable_reg <= REG_RESET;
         sense_lo <= REG_RESET;
         sense_hi <= REG_RESET;
         group0_mask_reg <= REG_RESET;
         group1_mask_reg <= REG_RESET;
         group2_mask_reg <= REG_RESET;
         group_enable_reg <= GRP_RESET;
         ext_line_flags <= REG_RESET;
         group_flags <= GRP_RESET;
      end else begin
         ext_line_enable_reg <= next_ext_en;
         sense_lo <= next_sense_lo;
         sense_hi <= next_sense_hi;
         group0_mask_reg <= next_mask0;
         group1_mask_reg <= next_mask1;
         group2_mask_reg <= next_mask2;
         group_enable_reg <= next_grp_en;
         ext_line_flags <= next_ext_flags;
         group_flags <= next_grp_flags;
      end
   end

   // -----------------------------------------
   // Register reads
   // -----------------------------------------
   always_comb begin
      next_rdata = REG_RESET;
      if (i_rd) begin
         case (i_addr)
            ADDR_EXT_FLAG: next_rdata = ext_line_flags;
            ADDR_EXT_EN: next_rdata = ext_line_enable_reg;
            ADDR_SENSE_LO: next_rdata = sense_lo;
            ADDR_SENSE_HI: next_rdata = sense_hi;
            ADDR_MASK0: next_rdata = group0_mask_reg;
            ADDR_MASK1: next_rdata = group1_mask_reg;
            ADDR_MASK2: next_rdata = group2_mask_reg;
            ADDR_GRP_EN: next_rdata = {5'h00, group_enable_reg};
            ADDR_GRP_FLAG: next_rdata = {5'h00, group_flags};
            default: next_rdata = REG_RESET;
         endcase
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_rdata <= REG_RESET;
      end else begin
         o_rdata <= next_rdata;
      end
   end

   // -----------------------------------------
   // Vector requests and interrupt line
   // -----------------------------------------
   always_comb begin
      o_ext_req = ext_line_enable_reg & {EXT_NUM{i_global_irq_en}}
         & ((ext_line_flags & ~det.level_mode) | (det.pin_low & det.level_mode));
      o_grp_req = group_flags & group_enable_reg & {GRP_NUM{i_global_irq_en}};
      o_irq = |{o_ext_req, o_grp_req};
   end

   // -----------------------------------------
   // Assertions
   // -----------------------------------------
   sequence s_ext_ack;
      i_vec_ack && (i_vec_idx < VEC_GRP_BASE) && !det.trig[i_vec_idx[2:0]];
   endsequence

   sequence s_grp_ack;
      i_vec_ack && (i_vec_idx >= VEC_GRP_BASE) && (i_vec_idx < VEC_GRP_BASE + 4'h3)
         && !grp_set[2'(i_vec_idx - VEC_GRP_BASE)];
   endsequence

   sequence s_flag_write;
      i_wr && (i_addr == ADDR_EXT_FLAG) && !i_vec_ack && (det.trig == 8'h00);
   endsequence

   AST_EXT_FLAG_SET: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      (det.trig != 8'h00) |=> ((ext_line_flags & $past(det.trig)) == $past(det.trig)))
      else $error("External trigger did not set its flag");

   AST_EXT_REQ_GATE: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      (o_ext_req != 8'h00) |-> i_global_irq_en
         && ((o_ext_req & ~ext_line_enable_reg) == 8'h00))
      else $error("External request without enables");

   AST_EXT_ACK_CLEAR: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      s_ext_ack |=> !ext_line_flags[$past(i_vec_idx[2:0])])
      else $error("Acknowledged external flag still set");

   AST_GRP_ACK_CLEAR: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      s_grp_ack |=> !group_flags[2'($past(i_vec_idx) - VEC_GRP_BASE)])
      else $error("Acknowledged group flag still set");

   AST_W1C_CLEAR: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      s_flag_write |=> ((ext_line_flags & $past(i_wdata)) == 8'h00))
      else $error("Written one did not clear flag");

   AST_W0_KEEP: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      s_flag_write ##0 (i_wdata == 8'h00)
      |=> ((ext_line_flags & $past(ext_line_flags & ~det.level_mode))
         == $past(ext_line_flags & ~det.level_mode)))
      else $error("Written zero changed a flag");

   AST_LEVEL_ZERO: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      ##1 ((ext_line_flags & $past(det.level_mode)) == 8'h00))
      else $error("Flag set in low level mode");

   AST_SLEEP_CLAMP: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      i_sleep |-> ((det.pin_low[SLEEP_LINES-1:0] | ext_line_enable_reg[SLEEP_LINES-1:0])
         == '1))
      else $error("Disabled line not clamped in sleep");

   AST_GRP_SET: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      (grp_set != 3'h0) |=> ((group_flags & $past(grp_set)) == $past(grp_set)))
      else $error("Pin change did not set group flag");

   AST_GRP_REQ: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      (group_flags[0] && group_enable_reg[0] && i_global_irq_en) |-> o_grp_req[0] && o_irq)
      else $error("Group request missing");

   AST_GRP_GATE: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      (o_grp_req & ~(group_flags & group_enable_reg)) == 3'h0)
      else $error("Group request without flag and enable");

   AST_MASKED_IGNORED: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      (group0_mask_reg == 8'h00) && !group_flags[0] && !(i_wr && i_addr == ADDR_MASK0)
      |=> !group_flags[0])
      else $error("Masked pin set group flag");

   AST_MAP_GROUP2: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      ((chg[23:16] & group2_mask_reg) != 8'h00) |=> group_flags[2])
      else $error("Group 2 pin change not mapped");

   // -----------------------------------------
   // Request path checks
   // -----------------------------------------
   sequence s_grp0_change;
      (chg[7:0] & group0_mask_reg) != 8'h00;
   endsequence

   sequence s_grp1_change;
      (chg[15:8] & group1_mask_reg) != 8'h00;
   endsequence

   sequence s_grp2_change;
      (chg[23:16] & group2_mask_reg) != 8'h00;
   endsequence

   AST_GRP0_REQ: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      s_grp0_change ##1 (group_enable_reg[0] && i_global_irq_en) |-> o_grp_req[0])
      else $error("Group 0 change gave no request");

   AST_GRP1_REQ: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      s_grp1_change ##1 (group_enable_reg[1] && i_global_irq_en) |-> o_grp_req[1])
      else $error("Group 1 change gave no request");

   AST_GRP2_REQ: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      s_grp2_change ##1 (group_enable_reg[2] && i_global_irq_en) |-> o_grp_req[2])
      else $error("Group 2 change gave no request");

   AST_EXT_REQ_SET: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      i_global_irq_en |-> ((o_ext_req & ext_line_flags & ext_line_enable_reg
         & ~det.level_mode) == (ext_line_flags & ext_line_enable_reg & ~det.level_mode)))
      else $error("Flagged enabled line gave no request");

   AST_LEVEL_REQ: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      i_global_irq_en |-> ((o_ext_req & det.level_mode & ext_line_enable_reg)
         == (det.pin_low & det.level_mode & ext_line_enable_reg)))
      else $error("Low level request does not follow the pin");

   AST_IRQ_ANY: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      o_irq == ((o_ext_req != 8'h00) || (o_grp_req != 3'h0)))
      else $error("Interrupt line does not match the requests");

   AST_GRP_W1C: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      i_wr && (i_addr == ADDR_GRP_FLAG) && (grp_set == 3'h0)
      |=> ((group_flags & $past(i_wdata[2:0])) == 3'h0))
      else $error("Written one did not clear group flag");

endmodule : eicpin_top

// ### eicpin_board.sv
// Board circuitry model that drives the external and pin change lines
`timescale 1ns/1ps
module eicpin_board (
   input wire logic i_sys_clk,
   input wire logic [7:0] i_ext_lvl,
   input wire logic [23:0] i_chg_lvl,
   output logic [7:0] o_ext_pins,
   output logic [23:0] o_change_pins
);
   // ----------------------------------------
   // Pins move half a cycle away from the core clock edge
   // ----------------------------------------
   always @(negedge i_sys_clk) begin
      o_ext_pins <= i_ext_lvl;
      o_change_pins <= i_chg_lvl;
   end
endmodule : eicpin_board

// ### ext_and_pin_change_irq_flags_bench.sv
// Self-checking bench for the pin interrupt flag block
`timescale 1ns/1ps
module ext_and_pin_change_irq_flags_bench;
   import eicpin_pkg::*;
   logic i_sys_clk = 1'b0;
   logic i_rst_b = 1'b0;
   eicpin_byte_t i_addr = 8'h00;
   eicpin_byte_t i_wdata = 8'h00;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   eicpin_byte_t o_rdata;
   logic [7:0] ext_pins;
   logic [23:0] change_pins;
   logic [7:0] ext_lvl = 8'h00;
   logic [23:0] chg_lvl = 24'h000000;
   logic i_global_irq_en = 1'b1;
   logic i_sleep = 1'b0;
   logic i_vec_ack = 1'b0;
   eicpin_vidx_t i_vec_idx = 4'h0;
   logic [7:0] o_ext_req;
   logic [2:0] o_grp_req;
   logic o_irq;
   int mismatches = 0;
   int tests_run = 0;
   // ----------------------------------------
   // Clock, design and board
   // ----------------------------------------
   always #4 i_sys_clk = ~i_sys_clk;
   eicpin_top u_dut (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ext_pins(ext_pins),
      .i_change_pins(change_pins), .i_global_irq_en(i_global_irq_en), .i_sleep(i_sleep),
      .i_vec_ack(i_vec_ack), .i_vec_idx(i_vec_idx), .o_ext_req(o_ext_req),
      .o_grp_req(o_grp_req), .o_irq(o_irq));
   eicpin_board u_board (.i_sys_clk(i_sys_clk), .i_ext_lvl(ext_lvl), .i_chg_lvl(chg_lvl),
      .o_ext_pins(ext_pins), .o_change_pins(change_pins));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge i_sys_clk);
      #1;
   endtask : tick
   task automatic wr(input eicpin_byte_t a, input eicpin_byte_t d);
      @(posedge i_sys_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_sys_clk);
      i_wr <= 1'b0;
   endtask : wr
   task automatic rd(input eicpin_byte_t a, input eicpin_byte_t e);
      @(posedge i_sys_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_sys_clk);
      i_rd <= 1'b0;
      #1;
      chk(o_rdata, e);
   endtask : rd
   task automatic ack_and_gie(input eicpin_vidx_t idx);
      @(posedge i_sys_clk);
      i_global_irq_en <= 1'b0;
      #1;
      chk(o_ext_req, 8'h00);
      chk({5'h00, o_grp_req}, 8'h00);
      chk({7'h00, o_irq}, 8'h00);
      @(posedge i_sys_clk);
      i_global_irq_en <= 1'b1;
      i_vec_idx <= idx;
      i_vec_ack <= 1'b1;
      @(posedge i_sys_clk);
      i_vec_ack <= 1'b0;
      #1;
      chk(o_ext_req, 8'h00);
      chk({5'h00, o_grp_req}, 8'h00);
   endtask : ack_and_gie
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic reg_map;
      eicpin_byte_t al[10];
      al = '{ADDR_EXT_FLAG, ADDR_EXT_EN, ADDR_SENSE_LO, ADDR_SENSE_HI, ADDR_MASK0,
         ADDR_MASK1, ADDR_MASK2, ADDR_GRP_EN, ADDR_GRP_FLAG, 8'h50};
      foreach (al[i]) rd(al[i], REG_RESET);
      wr(ADDR_MASK1, 8'ha5);
      wr(8'h50, 8'hff);
      rd(ADDR_MASK1, 8'ha5);
      rd(8'h50, 8'h00);
      wr(ADDR_GRP_EN, 8'hff);
      rd(ADDR_GRP_EN, 8'h07);
      wr(ADDR_GRP_EN, 8'h00);
      wr(ADDR_MASK1, 8'h00);
   endtask : reg_map
   task automatic ext_edges;
      logic [1:0] m;
      logic [7:0] er;
      logic [7:0] ef;
      for (int n = 0; n < 8; n++) begin
         m = 2'(1 + n % 3);
         er = (m != SENSE_FALL) ? (8'h01 << n) : 8'h00;
         ef = (m != SENSE_RISE) ? (8'h01 << n) : 8'h00;
         wr(ADDR_EXT_EN, 8'h00);
         wr((n < 4) ? ADDR_SENSE_LO : ADDR_SENSE_HI, 8'(m) << (2 * (n % 4)));
         wr(ADDR_EXT_FLAG, 8'hff);
         wr(ADDR_EXT_EN, 8'h01 << n);
         @(posedge i_sys_clk);
         ext_lvl[n] <= 1'b1;
         tick(2);
         chk(o_ext_req, 8'h00);
         tick(1);
         chk(o_ext_req, er);
         chk({7'h00, o_irq}, {7'h00, |er});
         rd(ADDR_EXT_FLAG, er);
         wr(ADDR_EXT_FLAG, 8'h00);
         rd(ADDR_EXT_FLAG, er);
         wr(ADDR_EXT_FLAG, ~(8'h01 << n));
         rd(ADDR_EXT_FLAG, er);
         wr(ADDR_EXT_FLAG, 8'h01 << n);
         rd(ADDR_EXT_FLAG, 8'h00);
         @(posedge i_sys_clk);
         ext_lvl[n] <= 1'b0;
         tick(4);
         chk(o_ext_req, ef);
         ack_and_gie(4'(n));
         chk(o_ext_req, 8'h00);
      end
   endtask : ext_edges
   task automatic ext_level_and_sleep;
      wr(ADDR_SENSE_HI, 8'h08);
      wr(ADDR_SENSE_LO, 8'h00);
      wr(ADDR_EXT_EN, 8'h04);
      tick(4);
      chk(o_ext_req, 8'h04);
      rd(ADDR_EXT_FLAG, 8'h00);
      @(posedge i_sys_clk);
      ext_lvl <= 8'h26;
      tick(4);
      chk(o_ext_req, 8'h00);
      wr(ADDR_EXT_EN, 8'h00);
      wr(ADDR_SENSE_LO, 8'h08);
      wr(ADDR_EXT_FLAG, 8'hff);
      @(posedge i_sys_clk);
      i_sleep <= 1'b1;
      tick(4);
      rd(ADDR_EXT_FLAG, 8'h02);
      @(posedge i_sys_clk);
      i_sleep <= 1'b0;
      ext_lvl <= 8'h00;
      tick(4);
      wr(ADDR_EXT_FLAG, 8'hff);
      rd(ADDR_EXT_FLAG, 8'h00);
   endtask : ext_level_and_sleep
   task automatic groups;
      int p;
      for (int g = 0; g < 3; g++) begin
         p = 8 * g + g + 2;
         wr(ADDR_GRP_EN, 8'h01 << g);
         wr(ADDR_MASK0 + 8'(g), 8'h01 << (g + 2));
         @(posedge i_sys_clk);
         chg_lvl[p + 1] <= 1'b1;
         tick(4);
         chk({5'h00, o_grp_req}, 8'h00);
         rd(ADDR_GRP_FLAG, 8'h00);
         @(posedge i_sys_clk);
         chg_lvl[p] <= 1'b1;
         tick(4);
         chk({5'h00, o_grp_req}, 8'h01 << g);
         rd(ADDR_GRP_FLAG, 8'h01 << g);
         ack_and_gie(VEC_GRP_BASE + 4'(g));
         rd(ADDR_GRP_FLAG, 8'h00);
         @(posedge i_sys_clk);
         chg_lvl[p] <= 1'b0;
         tick(4);
         rd(ADDR_GRP_FLAG, 8'h01 << g);
         wr(ADDR_GRP_FLAG, 8'h00);
         rd(ADDR_GRP_FLAG, 8'h01 << g);
         wr(ADDR_GRP_FLAG, 8'h01 << g);
         rd(ADDR_GRP_FLAG, 8'h00);
      end
   endtask : groups
   // ----------------------------------------
   // Run control
   // ----------------------------------------
   task automatic complete_run;
      $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : complete_run
   initial begin
      #200000;
      mismatches++;
      complete_run();
   end
   initial begin
      repeat (3) @(posedge i_sys_clk);
      i_rst_b <= 1'b1;
      reg_map();
      ext_edges();
      ext_level_and_sleep();
      groups();
      complete_run();
   end
endmodule : ext_and_pin_change_irq_flags_bench
